//--- common/iwc_cfg.svh
// Purpose: offsets, field positions, reset values and vector layout
// Assumes: register index times four is the byte address
// Notes:   definitions only
`ifndef IWC_CFG_SVH
`define IWC_CFG_SVH
// register indices
`define IWC_IDX_POWER 8'h87
`define IWC_IDX_TMRPIN 8'h88
`define IWC_IDX_FLAGS 8'h95
`define IWC_IDX_P1WAKE 8'h96
`define IWC_IDX_EN_MAIN 8'ha8
`define IWC_IDX_EN_EXTRA 8'ha9
`define IWC_IDX_PLO_MAIN 8'hb8
`define IWC_IDX_PHI_MAIN 8'hb9
`define IWC_IDX_PLO_EXTRA 8'hba
`define IWC_IDX_PHI_EXTRA 8'hbb
`define IWC_IDX_CLKCTL 8'hd8
// field positions
`define IWC_BIT_GATE 7
`define IWC_BIT_IDLE 0
`define IWC_BIT_STOP 1
`define IWC_BIT_A_TRIG 0
`define IWC_BIT_A_FLAG 1
`define IWC_BIT_B_TRIG 2
`define IWC_BIT_B_FLAG 3
`define IWC_BIT_C_FLAG 2
`define IWC_BIT_P1_FLAG 1
`define IWC_BIT_C_EN 2
`define IWC_BIT_CLKSTOP 4
// reset values
`define IWC_RST_BYTE 8'h00
`define IWC_RST_PIN 11'h7ff
// sources and vectors
`define IWC_NSRC 13
`define IWC_SLOT_A 4'h0
`define IWC_SLOT_B 4'h2
`define IWC_SLOT_P1 4'h8
`define IWC_SLOT_C 4'h9
`define IWC_ALIVE_MASK 13'h0385
`define IWC_VEC_BASE 16'h0003
`define IWC_VEC_RESV 16'h0033
`endif

//--- common/iwc_pkg.sv
// Purpose: shared types of the interrupt and wake-up controller
// Assumes: nothing
// Notes:   constants live in iwc_cfg.svh
package iwc_pkg;
    // one-hot power state
    typedef enum logic [2:0] {
        IWC_RUN = 3'b001,
        IWC_IDLE = 3'b010,
        IWC_STOP = 3'b100
    } iwc_pwr_t;
    typedef logic [1:0] iwc_lvl_t;
endpackage

//--- core/iwc_prio.sv
// Purpose: picks the highest-level pending source
// Assumes: pending already gated by enables
// Notes:   ties go to the lower slot number
`timescale 1ns/1ps
`default_nettype none
`include "iwc_cfg.svh"
module iwc_prio (
    input wire logic [12:0] pend,
    input wire logic [12:0] hi,
    input wire logic [12:0] lo,
    output logic vld,
    output logic [3:0] idx,
    output iwc_pkg::iwc_lvl_t lvl
);
    iwc_pkg::iwc_lvl_t lv_w [0:12];
    genvar g;
    for (g = 0; g < `IWC_NSRC; g++) begin : g_lvl
        assign lv_w[g] = {hi[g], lo[g]};
    end
    // descending scan with >= lets the lowest slot win a tie
    // tie order
    always_comb begin
        vld = 1'b0;
        idx = 4'h0;
        lvl = 2'b00;
        for (int i = `IWC_NSRC - 1; i >= 0; i--) begin
            if (pend[i] && (!vld || lv_w[i] >= lvl)) begin
                vld = 1'b1;
                idx = 4'(i);
                lvl = lv_w[i];
            end
        end
    end
endmodule
`default_nettype wire

//--- core/iwc_top.sv
// Purpose: interrupt and wake-up controller, Wishbone slave
// Assumes: CPU pulses CPU_ACK on entry, CPU_RETI on return
// Notes:   pins are synchronised; stop clock gating is external
//
// Functional notes
// - twelve sources, each on one of four levels
// - any enabled source ends idle; only pin sources end stop
// - events set pending flags regardless of enables
// - vectors 8 bytes apart from 0x0003, multi-flag sources ORed
// - slot at 0x0033 is never requested
// - service waits while equal or higher level is in service
// - higher level preempts; lower resumes after it returns
// - global gate off blocks all; on, each enable gates its source
// - every source has its own enable bit
// - pin enables also arm stop wake-up, regardless of global gate
// - per-pin port-1 wake mask, bit n for pin n
// - port-1 irq enable gates CPU service and idle wake, not stop wake
// - level is high bit and low bit, 11 highest
// - pins a and b: trigger type 0 low level, 1 falling edge
// - pin c falling edge only; port-1 any change of enabled pin
// - pin edge flags and port-1 flag clear on service entry
// - port-1 flag sets only for masked-in pins
// - flag register: write 0 clears, write 1 keeps
// - idle wake needs source enable and global gate
// - idle wake enters service at once
// - after stop wake the next instruction runs before service
// - after stop wake service needs gate, enables and a seen trigger
// - peripheral clock stop in idle leaves only timer3 and pins
// - stop entry refused while an enabled pin a, b or c is low
`timescale 1ns/1ps
`default_nettype none
`include "iwc_cfg.svh"
module iwc_top (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [9:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic EXT_PIN_A,
    input wire logic EXT_PIN_B,
    input wire logic EXT_PIN_C,
    input wire logic [7:0] PORT1_PIN,
    input wire logic [13:0] PERIPH_FLAG,
    input wire logic CPU_ACK,
    input wire logic CPU_RETI,
    input wire logic CPU_STEP,
    output logic INT_REQ,
    output logic [15:0] INT_VECTOR,
    output logic [1:0] INT_LEVEL,
    output logic IDLE_MODE,
    output logic STOP_MODE
);
    // ****************************************************
    // declarations
    // ****************************************************
    iwc_pkg::iwc_pwr_t st_r, st_nxt;
    logic ack_r;
    logic [7:0] dat_r;
    logic [7:0] pwr_misc_r, tmrpin_r, p1_mask_r, en_main_r, en_extra_r;
    logic [5:0] plo_main_r, phi_main_r, plo_extra_r, phi_extra_r;
    logic clkstop_r;
    logic fl_a_r, fl_b_r, fl_c_r, fl_p1_r;
    logic fl_a_nxt, fl_b_nxt, fl_c_nxt, fl_p1_nxt;
    logic req_r, req_nxt, hold_r;
    logic [3:0] idx_r;
    iwc_pkg::iwc_lvl_t lvl_r;
    logic [3:0] in_svc_r, in_svc_nxt;
    logic [10:0] pin_w, lvl_s_w, fall_w, chg_w;
    // ****************************************************
    // pin synchronisers and edge detect
    // ****************************************************
    assign pin_w = {PORT1_PIN, EXT_PIN_C, EXT_PIN_B, EXT_PIN_A};
    // clockless wake
    // two sync flops and one edge flop per pin; the stopped-clock wake path is the
    // external clock gate's job, this logic sees pins once it runs
    genvar g;
    for (g = 0; g < 11; g++) begin : g_sync
        logic s1_r, s2_r, prev_r;
        always_ff @(posedge MCLK) begin
            if (!RST_N) begin
                s1_r <= 1'b1;
                s2_r <= 1'b1;
                prev_r <= 1'b1;
            end else begin
                s1_r <= pin_w[g];
                s2_r <= s1_r;
                prev_r <= s2_r;
            end
        end
        assign lvl_s_w[g] = s2_r;
        assign fall_w[g] = prev_r & ~s2_r;
        assign chg_w[g] = prev_r ^ s2_r;
    end
    // ****************************************************
    // bus decode
    // ****************************************************
    wire req_w = WB_CYC_I & WB_STB_I & ~ack_r;
    wire wr_w = req_w & WB_WE_I & WB_SEL_I[0];
    wire [7:0] wd = WB_DAT_I[7:0];
    wire [7:0] idx_w = WB_ADR_I[9:2];
    wire wr_pwr = wr_w & (idx_w == `IWC_IDX_POWER);
    wire wr_tp = wr_w & (idx_w == `IWC_IDX_TMRPIN);
    wire wr_fl = wr_w & (idx_w == `IWC_IDX_FLAGS);
    wire wr_p1 = wr_w & (idx_w == `IWC_IDX_P1WAKE);
    wire wr_enm = wr_w & (idx_w == `IWC_IDX_EN_MAIN);
    wire wr_enx = wr_w & (idx_w == `IWC_IDX_EN_EXTRA);
    wire wr_plm = wr_w & (idx_w == `IWC_IDX_PLO_MAIN);
    wire wr_phm = wr_w & (idx_w == `IWC_IDX_PHI_MAIN);
    wire wr_plx = wr_w & (idx_w == `IWC_IDX_PLO_EXTRA);
    wire wr_phx = wr_w & (idx_w == `IWC_IDX_PHI_EXTRA);
    wire wr_clk = wr_w & (idx_w == `IWC_IDX_CLKCTL);
    // ****************************************************
    // sources, enables, levels
    // ****************************************************
    wire gate = en_main_r[`IWC_BIT_GATE];
    wire en_a = en_main_r[0];
    wire en_b = en_main_r[2];
    wire en_c = en_extra_r[`IWC_BIT_C_EN];
    wire trig_a = tmrpin_r[`IWC_BIT_A_TRIG];
    wire trig_b = tmrpin_r[`IWC_BIT_B_TRIG];
    wire src_a = trig_a ? fl_a_r : ~lvl_s_w[0];
    wire src_b = trig_b ? fl_b_r : ~lvl_s_w[1];
    // vector order
    // multi-flag peripherals are ORed into one slot; slot 6 is dead
    wire [12:0] pend_w = {
        PERIPH_FLAG[12] | PERIPH_FLAG[13],
        PERIPH_FLAG[9] | PERIPH_FLAG[10] | PERIPH_FLAG[11],
        PERIPH_FLAG[7] | PERIPH_FLAG[8],
        fl_c_r, fl_p1_r, PERIPH_FLAG[6],
        1'b0,
        PERIPH_FLAG[4] | PERIPH_FLAG[5],
        PERIPH_FLAG[2] | PERIPH_FLAG[3],
        PERIPH_FLAG[1], src_b, PERIPH_FLAG[0], src_a};
    wire [12:0] en_w = {en_extra_r[5:0], 1'b0, en_main_r[5:0]};
    wire [12:0] hi_w = {phi_extra_r, 1'b0, phi_main_r};
    wire [12:0] lo_w = {plo_extra_r, 1'b0, plo_main_r};
    wire [12:0] alive_w = (st_r == iwc_pkg::IWC_IDLE && clkstop_r) ?
        `IWC_ALIVE_MASK : {`IWC_NSRC{1'b1}};
    wire [12:0] act_w = pend_w & en_w & alive_w & {`IWC_NSRC{gate}};
    logic win_vld;
    logic [3:0] win_idx;
    iwc_pkg::iwc_lvl_t win_lvl;
    iwc_prio u_prio (
        .pend(act_w),
        .hi(hi_w),
        .lo(lo_w),
        .vld(win_vld),
        .idx(win_idx),
        .lvl(win_lvl)
    );
    // ****************************************************
    // service tracking
    // ****************************************************
    // equal level waits
    wire blocked = (in_svc_r >> win_lvl) != 4'h0;
    wire ent_w = CPU_ACK & req_r;
    wire ent_a = ent_w & (idx_r == `IWC_SLOT_A);
    wire ent_b = ent_w & (idx_r == `IWC_SLOT_B);
    wire ent_c = ent_w & (idx_r == `IWC_SLOT_C);
    wire ent_p1 = ent_w & (idx_r == `IWC_SLOT_P1);
    assign req_nxt = win_vld & ~blocked & ~hold_r & ~CPU_ACK &
        (st_r != iwc_pkg::IWC_STOP);
    // highest level in service, cleared on return
    wire [3:0] top_w = in_svc_r[3] ? 4'h8 : in_svc_r[2] ? 4'h4 :
        in_svc_r[1] ? 4'h2 : in_svc_r[0] ? 4'h1 : 4'h0;
    wire [3:0] clr_svc = CPU_RETI ? top_w : 4'h0;
    wire [3:0] set_svc = ent_w ? (4'h1 << lvl_r) : 4'h0;
    assign in_svc_nxt = (in_svc_r & ~clr_svc) | set_svc;
    // request, vector and nesting state
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            req_r <= 1'b0;
            idx_r <= 4'h0;
            lvl_r <= 2'b00;
            in_svc_r <= 4'h0;
        end else begin
            req_r <= req_nxt;
            idx_r <= win_idx;
            lvl_r <= win_lvl;
            in_svc_r <= in_svc_nxt;
        end
    end
    // ****************************************************
    // pin flags
    // ****************************************************
    // flags ignore enables
    wire set_a = fall_w[0] & trig_a;
    wire set_b = fall_w[1] & trig_b;
    wire set_c = fall_w[2];
    wire set_p1 = |(chg_w[10:3] & p1_mask_r);
    // write zero clears
    // a set in the clearing cycle wins
    assign fl_a_nxt = set_a | (wr_tp ? wd[`IWC_BIT_A_FLAG] : fl_a_r & ~ent_a);
    assign fl_b_nxt = set_b | (wr_tp ? wd[`IWC_BIT_B_FLAG] : fl_b_r & ~ent_b);
    assign fl_c_nxt = set_c | (fl_c_r & ~ent_c & ~(wr_fl & ~wd[`IWC_BIT_C_FLAG]));
    assign fl_p1_nxt = set_p1 |
        (fl_p1_r & ~ent_p1 & ~(wr_fl & ~wd[`IWC_BIT_P1_FLAG]));
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            fl_a_r <= 1'b0;
            fl_b_r <= 1'b0;
            fl_c_r <= 1'b0;
            fl_p1_r <= 1'b0;
        end else begin
            fl_a_r <= fl_a_nxt;
            fl_b_r <= fl_b_nxt;
            fl_c_r <= fl_c_nxt;
            fl_p1_r <= fl_p1_nxt;
        end
    end
    // ****************************************************
    // power modes
    // ****************************************************
    // stop refusal
    wire pin_low_w = (en_a & ~lvl_s_w[0]) | (en_b & ~lvl_s_w[1]) |
        (en_c & ~lvl_s_w[2]);
    wire stop_wake = pin_low_w | set_p1;
    wire idle_wake = |act_w;
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            iwc_pkg::IWC_RUN: begin
                if (wr_pwr && wd[`IWC_BIT_STOP] && !pin_low_w) begin
                    st_nxt = iwc_pkg::IWC_STOP;
                end else if (wr_pwr && wd[`IWC_BIT_IDLE]) begin
                    st_nxt = iwc_pkg::IWC_IDLE;
                end
            end
            iwc_pkg::IWC_IDLE: begin
                if (idle_wake) begin
                    st_nxt = iwc_pkg::IWC_RUN;
                end
            end
            iwc_pkg::IWC_STOP: begin
                if (stop_wake) begin
                    st_nxt = iwc_pkg::IWC_RUN;
                end
            end
            default: st_nxt = iwc_pkg::IWC_RUN;
        endcase
    end
    // service after stop wake
    // hold stays until the CPU retires one instruction
    wire stop_exit = (st_r == iwc_pkg::IWC_STOP) && (st_nxt == iwc_pkg::IWC_RUN);
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            st_r <= iwc_pkg::IWC_RUN;
            hold_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            hold_r <= stop_exit | (hold_r & ~CPU_STEP);
        end
    end
    // ****************************************************
    // register file and bus answer
    // ****************************************************
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            pwr_misc_r <= `IWC_RST_BYTE;
            tmrpin_r <= `IWC_RST_BYTE;
            p1_mask_r <= `IWC_RST_BYTE;
            en_main_r <= `IWC_RST_BYTE;
            en_extra_r <= `IWC_RST_BYTE;
            clkstop_r <= 1'b0;
        end else begin
            if (wr_pwr) pwr_misc_r <= wd & 8'h8c;
            if (wr_tp) tmrpin_r <= wd;
            if (wr_p1) p1_mask_r <= wd;
            if (wr_enm) en_main_r <= wd & 8'hbf;
            if (wr_enx) en_extra_r <= wd & 8'h3f;
            if (wr_clk) clkstop_r <= wd[`IWC_BIT_CLKSTOP];
        end
    end
    // priority bits, six per register
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            plo_main_r <= 6'h00;
            phi_main_r <= 6'h00;
            plo_extra_r <= 6'h00;
            phi_extra_r <= 6'h00;
        end else begin
            if (wr_plm) plo_main_r <= wd[5:0];
            if (wr_phm) phi_main_r <= wd[5:0];
            if (wr_plx) plo_extra_r <= wd[5:0];
            if (wr_phx) phi_extra_r <= wd[5:0];
        end
    end
    // read view; unmapped indices answer zero
    wire [7:0] rd_pwr = {pwr_misc_r[7:2], st_r == iwc_pkg::IWC_STOP,
        st_r == iwc_pkg::IWC_IDLE};
    wire [7:0] rd_tp = {tmrpin_r[7:4], fl_b_r, trig_b, fl_a_r, trig_a};
    wire [7:0] rd_fl = {2'b00, PERIPH_FLAG[8], PERIPH_FLAG[7], 1'b0,
        fl_c_r, fl_p1_r, PERIPH_FLAG[6]};
    wire [7:0] rd_w =
        (idx_w == `IWC_IDX_POWER) ? rd_pwr :
        (idx_w == `IWC_IDX_TMRPIN) ? rd_tp :
        (idx_w == `IWC_IDX_FLAGS) ? rd_fl :
        (idx_w == `IWC_IDX_P1WAKE) ? p1_mask_r :
        (idx_w == `IWC_IDX_EN_MAIN) ? en_main_r :
        (idx_w == `IWC_IDX_EN_EXTRA) ? en_extra_r :
        (idx_w == `IWC_IDX_PLO_MAIN) ? {2'b00, plo_main_r} :
        (idx_w == `IWC_IDX_PHI_MAIN) ? {2'b00, phi_main_r} :
        (idx_w == `IWC_IDX_PLO_EXTRA) ? {2'b00, plo_extra_r} :
        (idx_w == `IWC_IDX_PHI_EXTRA) ? {2'b00, phi_extra_r} :
        (idx_w == `IWC_IDX_CLKCTL) ? {3'b000, clkstop_r, 4'h0} : 8'h00;
    // one-cycle answer, dropped the cycle after
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ack_r <= 1'b0;
            dat_r <= 8'h00;
        end else begin
            ack_r <= req_w;
            if (req_w) dat_r <= rd_w;
        end
    end
    // ****************************************************
    // outputs
    // ****************************************************
    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = {24'h00_0000, dat_r};
    assign INT_REQ = req_r;
    assign INT_VECTOR = `IWC_VEC_BASE + {9'h000, idx_r, 3'b000};
    assign INT_LEVEL = lvl_r;
    assign IDLE_MODE = st_r[1];
    assign STOP_MODE = st_r[2];
    // ****************************************************
    // checks
    // ****************************************************
    resv_slot_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        INT_REQ |-> INT_VECTOR != `IWC_VEC_RESV) else $error("reserved vector requested");
    gate_off_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !gate |=> !INT_REQ) else $error("request with gate off");
    equal_block_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        INT_REQ |-> (in_svc_r >> INT_LEVEL) == 4'h0) else $error("request blocked by level");
    stop_refuse_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (wr_pwr && wd[`IWC_BIT_STOP] && pin_low_w) |=> !STOP_MODE) else $error("stop not refused");
    flag_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (wr_fl && !wd[`IWC_BIT_C_FLAG] && !set_c) |=> !fl_c_r) else $error("flag write clear failed");
    entry_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (ent_p1 && !set_p1) |=> !fl_p1_r) else $error("entry did not clear flag");
    p1_cause_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        $rose(fl_p1_r) |-> $past(set_p1)) else $error("port-1 flag without cause");
    stop_resume_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        $fell(STOP_MODE) |-> hold_r ##1 !INT_REQ) else $error("service before resume");
    stop_wake_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (STOP_MODE && en_a && !lvl_s_w[0]) |=> !STOP_MODE) else $error("pin did not wake stop");
    idle_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (IDLE_MODE && !gate && !wr_pwr) |=> IDLE_MODE) else $error("idle left with gate off");
endmodule
`default_nettype wire

//--- sim/iwc_cpu_model.sv
// Purpose: cpu side stand-in that enters a routine whenever a request is shown
// Assumes: one entry pulse per request, returns and steps come from the bench
// Notes:   dly sets how many cycles it lets a request wait before entering
`timescale 1ns/1ps
`default_nettype none
// ********************
// cpu entry model
// ********************
module iwc_cpu_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [3:0] dly,
    input wire logic int_req,
    input wire logic [15:0] int_vector,
    input wire logic [1:0] int_level,
    output logic cpu_ack,
    output logic [15:0] last_vec,
    output logic [1:0] last_lvl,
    output int n_ent
);
    logic [3:0] wait_r;
    // one pulse per entry; the gap after it stops a second entry on a stale request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_ack <= 1'b0;
            wait_r <= 4'h0;
            last_vec <= 16'h0000;
            last_lvl <= 2'h0;
            n_ent <= 0;
        end else if (cpu_ack) begin
            cpu_ack <= 1'b0;
            wait_r <= 4'h0;
        end else if (en && int_req) begin
            if (wait_r >= dly) begin
                cpu_ack <= 1'b1;
                last_vec <= int_vector;
                last_lvl <= int_level;
                n_ent <= n_ent + 1;
                wait_r <= 4'h0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end else begin
            wait_r <= 4'h0;
        end
    end
endmodule
`default_nettype wire

//--- sim/interrupt_wakeup_controller_tb.sv
// Purpose: self-checking bench of the interrupt and wake-up controller
// Assumes: register bus single cycles, cpu model enters on every request
// Notes:   peripheral flags are levels, so the bench drops them after entry
`timescale 1ns/1ps
`default_nettype none
`include "iwc_cfg.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module interrupt_wakeup_controller_tb;
    // ********************
    // stimulus and wiring
    // ********************
    logic MCLK = 1'b0, RST_N = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
    logic [9:0] WB_ADR_I = 10'h000;
    logic [3:0] WB_SEL_I = 4'h1;
    logic [31:0] WB_DAT_I = 32'h0000_0000;
    logic EXT_PIN_A = 1'b1, EXT_PIN_B = 1'b1, EXT_PIN_C = 1'b1, CPU_RETI = 1'b0, CPU_STEP = 1'b0;
    logic [7:0] PORT1_PIN = 8'hff;
    logic [13:0] PERIPH_FLAG = 14'h0000;
    logic [3:0] m_dly = 4'h0;
    logic [31:0] WB_DAT_O;
    logic [15:0] INT_VECTOR, m_vec;
    logic [1:0] INT_LEVEL, m_lvl;
    logic WB_ACK_O, CPU_ACK, INT_REQ, IDLE_MODE, STOP_MODE;
    logic [7:0] rq;
    int m_n, n_errors = 0, num_checks = 0;

    // free running 100 MHz clock
    always #5 MCLK = ~MCLK;

    iwc_top i_dut (.MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .EXT_PIN_A(EXT_PIN_A), .EXT_PIN_B(EXT_PIN_B),
        .EXT_PIN_C(EXT_PIN_C), .PORT1_PIN(PORT1_PIN), .PERIPH_FLAG(PERIPH_FLAG), .CPU_ACK(CPU_ACK),
        .CPU_RETI(CPU_RETI), .CPU_STEP(CPU_STEP), .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR),
        .INT_LEVEL(INT_LEVEL), .IDLE_MODE(IDLE_MODE), .STOP_MODE(STOP_MODE));
    iwc_cpu_model i_cpu (.clk(MCLK), .rst_n(RST_N), .en(1'b1), .dly(m_dly), .int_req(INT_REQ),
        .int_vector(INT_VECTOR), .int_level(INT_LEVEL), .cpu_ack(CPU_ACK), .last_vec(m_vec),
        .last_lvl(m_lvl), .n_ent(m_n));

    // ********************
    // bus and cpu tasks
    // ********************
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
    endtask
    // request held until ack is sampled, then released for one idle cycle
    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= {idx, 2'b00};
        WB_DAT_I <= {24'h00_0000, d};
        do begin
            @(posedge MCLK);
            n++;
        end while (WB_ACK_O !== 1'b1 && n < 40);
        rq = WB_DAT_O[7:0];
        `CHK("bus ack", 1'b1, WB_ACK_O)
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
        @(posedge MCLK);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        `CHK($sformatf("reg %h", idx), e, rq)
    endtask
    // waits, bounded, for the cpu to enter past n0 entries and checks the vector
    task automatic ent(input int n0, input logic [15:0] v);
        int k;
        k = 0;
        while (m_n == n0 && k < 60) begin
            @(posedge MCLK);
            k++;
        end
        `CHK("entries", n0 + 1, m_n)
        `CHK("vector", v, m_vec)
    endtask
    task automatic ret();
        CPU_RETI <= 1'b1;
        @(posedge MCLK);
        CPU_RETI <= 1'b0;
        @(posedge MCLK);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ********************
    // tests
    // ********************
    // watchdog: the tests need well under two thousand cycles
    initial begin
        tick(20000);
        n_errors++;
        $display("ERROR watchdog exp done got hang");
        tally_and_finish();
    end
    initial begin
        tick(16);
        RST_N <= 1'b1;
        tick(2);
        `CHK("int_vector", `IWC_VEC_BASE, INT_VECTOR)
        `CHK("int_req", 1'b0, INT_REQ)
        rd(`IWC_IDX_EN_MAIN, 8'h00);
        rd(`IWC_IDX_P1WAKE, 8'h00);
        rd(`IWC_IDX_TMRPIN, 8'h00);
        wr(8'h10, 8'h5a);
        rd(8'h10, 8'h00);
        $display("test reset done");
        // pin flags set with enables off, cleared on entry or by writing zero
        wr(`IWC_IDX_TMRPIN, 8'h01);
        EXT_PIN_A <= 1'b0;
        EXT_PIN_C <= 1'b0;
        tick(8);
        rd(`IWC_IDX_TMRPIN, 8'h03);
        rd(`IWC_IDX_FLAGS, 8'h04);
        `CHK("entries", 0, m_n)
        EXT_PIN_A <= 1'b1;
        EXT_PIN_C <= 1'b1;
        wr(`IWC_IDX_EN_MAIN, 8'h81);
        ent(0, 16'h0003);
        ret();
        rd(`IWC_IDX_TMRPIN, 8'h01);
        wr(`IWC_IDX_FLAGS, 8'hff);
        rd(`IWC_IDX_FLAGS, 8'h04);
        wr(`IWC_IDX_FLAGS, 8'hfb);
        rd(`IWC_IDX_FLAGS, 8'h00);
        PORT1_PIN <= 8'hf7;
        tick(8);
        rd(`IWC_IDX_FLAGS, 8'h00);
        wr(`IWC_IDX_P1WAKE, 8'h08);
        PORT1_PIN <= 8'hff;
        tick(8);
        rd(`IWC_IDX_FLAGS, 8'h02);
        wr(`IWC_IDX_FLAGS, 8'hfd);
        rd(`IWC_IDX_FLAGS, 8'h00);
        $display("test pins done");
        // two timers pending on one level, then one raised above it
        wr(`IWC_IDX_EN_MAIN, 8'h0a);
        PERIPH_FLAG <= 14'h0003;
        tick(10);
        `CHK("entries", 1, m_n)
        wr(`IWC_IDX_EN_MAIN, 8'h8a);
        ent(1, 16'h000b);
        PERIPH_FLAG <= 14'h0002;
        tick(10);
        `CHK("entries", 2, m_n)
        wr(`IWC_IDX_PHI_MAIN, 8'h08);
        ent(2, 16'h001b);
        `CHK("level", 2'b10, m_lvl)
        PERIPH_FLAG <= 14'h0000;
        ret();
        ret();
        wr(`IWC_IDX_PHI_MAIN, 8'h00);
        $display("test priority done");
        // idle wake by a timer, stop refused, then stop wake by pin
        m_dly <= 4'h3;
        wr(`IWC_IDX_EN_MAIN, 8'h83);
        wr(`IWC_IDX_POWER, 8'h01);
        tick(1);
        `CHK("idle", 1'b1, IDLE_MODE)
        PERIPH_FLAG <= 14'h0001;
        ent(3, 16'h000b);
        `CHK("idle", 1'b0, IDLE_MODE)
        PERIPH_FLAG <= 14'h0000;
        ret();
        EXT_PIN_A <= 1'b0;
        tick(6);
        wr(`IWC_IDX_POWER, 8'h02);
        tick(1);
        `CHK("stop", 1'b0, STOP_MODE)
        ent(4, 16'h0003);
        ret();
        EXT_PIN_A <= 1'b1;
        tick(6);
        wr(`IWC_IDX_POWER, 8'h02);
        tick(1);
        `CHK("stop", 1'b1, STOP_MODE)
        PERIPH_FLAG <= 14'h0001;
        tick(10);
        `CHK("stop", 1'b1, STOP_MODE)
        PERIPH_FLAG <= 14'h0000;
        EXT_PIN_A <= 1'b0;
        tick(8);
        `CHK("stop", 1'b0, STOP_MODE)
        `CHK("entries", 5, m_n)
        CPU_STEP <= 1'b1;
        tick(1);
        CPU_STEP <= 1'b0;
        ent(5, 16'h0003);
        ret();
        EXT_PIN_A <= 1'b1;
        $display("test power done");
        // port-1 change held off by its enable, then served and cleared on entry
        PORT1_PIN <= 8'hf7;
        tick(8);
        `CHK("entries", 6, m_n)
        rd(`IWC_IDX_FLAGS, 8'h02);
        wr(`IWC_IDX_EN_EXTRA, 8'h02);
        ent(6, 16'h0043);
        rd(`IWC_IDX_FLAGS, 8'h00);
        ret();
        // idle with peripheral clocks stopped: timer ignored, pin still wakes
        wr(`IWC_IDX_CLKCTL, 8'h10);
        wr(`IWC_IDX_POWER, 8'h01);
        PERIPH_FLAG <= 14'h0001;
        tick(10);
        `CHK("idle", 1'b1, IDLE_MODE)
        PERIPH_FLAG <= 14'h0000;
        EXT_PIN_A <= 1'b0;
        ent(7, 16'h0003);
        `CHK("idle", 1'b0, IDLE_MODE)
        ret();
        EXT_PIN_A <= 1'b1;
        $display("test wake done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
